/* File: hdl/mcr_pkg.sv */
/*
  Package for the multiply-accumulate result path: command and answer
  carriers, mode codes, flag encodings and the register map of the
  AXI4-Lite window. Assumes a 32-bit AXI4-Lite bus and one clock.
*/
package mcr_pkg;

  // ----------------------------------------------------------------
  // Coprocessor command kinds and mode codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MCR_CMD_MODE_WRITE,
    MCR_CMD_INIT_LOAD,
    MCR_CMD_ARG_XFER,
    MCR_CMD_NONE
  } mcr_cmd_kind_type;

  localparam logic [3:0] MCR_OP_CLEAR   = 4'h0;
  localparam logic [3:0] MCR_OP_INIT16  = 4'h1;
  localparam logic [3:0] MCR_OP_INIT32  = 4'h2;
  localparam logic [3:0] MCR_OP_READ    = 4'h3;
  localparam logic [3:0] MCR_OP_MAC_U   = 4'h6;
  localparam logic [3:0] MCR_OP_MAC_S   = 4'h7;
  localparam logic [3:0] MCR_OP_INIT_B  = 4'ha;
  localparam int         MCR_MODE_W     = 7;
  localparam int         MCR_OP_MSB     = 3;
  localparam int         MCR_OUT_LSB    = 4;
  localparam logic [6:0] MCR_MODE_RESET = 7'h00;

  // Flags ordered C, V, Z, N
  localparam logic [3:0] MCR_FLAGS_OVF  = 4'h4;
  localparam logic [3:0] MCR_FLAGS_NONE = 4'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    mcr_cmd_kind_type kind;
    logic [15:0]      op_a;
    logic [15:0]      op_b;
  } mcr_cmd_type;

  typedef struct packed {
    logic [15:0] data;
    logic [3:0]  flags;
  } mcr_rsp_type;

  // ----------------------------------------------------------------
  // AXI4-Lite register map
  // ----------------------------------------------------------------
  localparam logic [7:0] MCR_ADDR_STATUS = 8'h00;
  localparam logic [7:0] MCR_ADDR_MASK   = 8'h04;
  localparam logic [7:0] MCR_ADDR_MODE   = 8'h08;
  localparam logic [7:0] MCR_ADDR_RES_A  = 8'h0c;
  localparam logic [7:0] MCR_ADDR_RES_B  = 8'h10;
  localparam logic [7:0] MCR_ADDR_FLAG   = 8'h14;
  localparam int         MCR_ST_OVF      = 0;
  localparam int         MCR_ST_ACC      = 1;
  localparam int         MCR_ST_W        = 2;
  localparam logic [1:0] MCR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] MCR_RESP_DECERR = 2'h3;

endpackage : mcr_pkg

/* File: hdl/mcr_result_path.sv */
/*
  Multiply-accumulate result path of the arithmetic coprocessor: two
  32-bit result registers, mode register, overflow flag, result readout,
  plus an AXI4-Lite window with sticky status and one interrupt.
  Assumes the CPU core issues at most one coprocessor command per clock
  and takes the answer one clock later; one clock, synchronous reset.
*/
`timescale 1ns/1ps

// Operation
// - MAC mode adds the 16x16 product into result A, 32 bits.
// - A coprocessor write of mode 0x00 clears both result registers at once.
// - Mode 0x01 load puts 16-bit value low, clears upper half.
// - Mode 0x02 load puts first operand high, second operand low.
// - 0x06 unsigned, 0x07 signed accumulate; output code picks half.
// - Accumulate flags are 0b0100 on overflow, else zero.
// - Overflow only detected in signed accumulate mode.
// - Overflow when like-signed addends give opposite-signed sum.
// - An overflowing accumulate step leaves result A unchanged.
// - Overflow clears on clean accumulate or non-read transfer or load.
// - Each transfer returns one selected 16-bit half plus flags.
// - Read mode 0x03/0x13/0x23/0x33 returns A low/high, B low/high.
// - Read transfers give zero flags and change no result register.
// - Result registers keep their value until overwritten.
// - Seven-bit mode: bits 5:4 output select, 3:0 operation.
module mcr_result_path (
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // Coprocessor command port
  input  wire logic                cop_valid,
  input  wire mcr_pkg::mcr_cmd_type cop_cmd,
  output      logic                cop_ans_valid,
  output      mcr_pkg::mcr_rsp_type cop_ans,
  // AXI4-Lite write channels
  input  wire logic                s_axi_awvalid,
  output      logic                s_axi_awready,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_wvalid,
  output      logic                s_axi_wready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  output      logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output      logic [1:0]          s_axi_bresp,
  // AXI4-Lite read channels
  input  wire logic                s_axi_arvalid,
  output      logic                s_axi_arready,
  input  wire logic [7:0]          s_axi_araddr,
  output      logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output      logic [31:0]         s_axi_rdata,
  output      logic [1:0]          s_axi_rresp,
  // Interrupt
  output      logic                irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [6:0]  mode_reg;
  logic [31:0] res_a_reg;
  logic [31:0] res_b_reg;
  logic        ovf_reg;
  logic [1:0]  status_reg;
  logic [1:0]  mask_reg;
  logic        aw_got_reg;
  logic        w_got_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic        wstrb0_reg;
  logic [3:0]  op;
  logic [1:0]  out_sel;
  logic        is_mode, is_load, is_arg, is_mac;
  logic [31:0] prod_u, prod_s, prod, sum;
  logic        ovf_now;
  logic [31:0] res_a_next, res_b_next;
  logic        wr_fire;
  logic [1:0]  status_next;
  logic [1:0]  w1c;

  assign op      = mode_reg[mcr_pkg::MCR_OP_MSB:0];
  assign out_sel = mode_reg[mcr_pkg::MCR_OUT_LSB+1:mcr_pkg::MCR_OUT_LSB];
  assign is_mode = cop_valid && cop_cmd.kind == mcr_pkg::MCR_CMD_MODE_WRITE;
  assign is_load = cop_valid && cop_cmd.kind == mcr_pkg::MCR_CMD_INIT_LOAD;
  assign is_arg  = cop_valid && cop_cmd.kind == mcr_pkg::MCR_CMD_ARG_XFER;
  assign is_mac  = op == mcr_pkg::MCR_OP_MAC_U || op == mcr_pkg::MCR_OP_MAC_S;

  // ----------------------------------------------------------------
  // Accumulate datapath
  // ----------------------------------------------------------------
  // Operands are taken as 16-bit values, immediates pre-extended by the CPU
  assign prod_u = {16'h0000, cop_cmd.op_a} * {16'h0000, cop_cmd.op_b};
  assign prod_s = $signed({{16{cop_cmd.op_a[15]}}, cop_cmd.op_a}) *
                  $signed({{16{cop_cmd.op_b[15]}}, cop_cmd.op_b});
  assign prod   = (op == mcr_pkg::MCR_OP_MAC_S) ? prod_s : prod_u;
  assign sum    = res_a_reg + prod;

  // Signed overflow only: like signs in, other sign out
  assign ovf_now = (op == mcr_pkg::MCR_OP_MAC_S) &&
                   ((!prod[31] && !res_a_reg[31] && sum[31]) ||
                    (prod[31] && res_a_reg[31] && !sum[31]));

  // Next result values; everything not named here keeps its value
  always_comb
  begin
    res_a_next = res_a_reg;
    res_b_next = res_b_reg;
    if (is_mode && cop_cmd.op_a[mcr_pkg::MCR_OP_MSB:0] == mcr_pkg::MCR_OP_CLEAR)
    begin
      res_a_next = 32'h0000_0000;
      res_b_next = 32'h0000_0000;
    end
    else if (is_load)
    begin
      case (op)
        mcr_pkg::MCR_OP_INIT16: res_a_next = {16'h0000, cop_cmd.op_b};
        mcr_pkg::MCR_OP_INIT32: res_a_next = {cop_cmd.op_a, cop_cmd.op_b};
        mcr_pkg::MCR_OP_INIT_B: res_b_next = {cop_cmd.op_a, cop_cmd.op_b};
        default:                res_a_next = res_a_reg;
      endcase
    end
    // An overflowing step leaves the old result in place
    else if (is_arg && is_mac && !ovf_now)
    begin
      res_a_next = sum;
    end
  end

  // ----------------------------------------------------------------
  // Coprocessor state: mode, results, overflow
  // ----------------------------------------------------------------
  // Mode register; a coprocessor write beats a bus write in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_reg <= mcr_pkg::MCR_MODE_RESET;
    else if (is_mode)
      mode_reg <= cop_cmd.op_a[6:0];
    else if (wr_fire && awaddr_reg == mcr_pkg::MCR_ADDR_MODE && wstrb0_reg)
      mode_reg <= wdata_reg[6:0];
  end

  // Result registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      res_a_reg <= 32'h0000_0000;
      res_b_reg <= 32'h0000_0000;
    end
    else
    begin
      res_a_reg <= res_a_next;
      res_b_reg <= res_b_next;
    end
  end

  // Overflow flag; read mode leaves it alone
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ovf_reg <= 1'b0;
    else if (is_arg && is_mac)
      ovf_reg <= ovf_now;
    else if ((is_arg || is_load) && op != mcr_pkg::MCR_OP_READ)
      ovf_reg <= 1'b0;
  end

  // Answer: selected half of the updated registers plus flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cop_ans_valid <= 1'b0;
      cop_ans       <= '0;
    end
    else
    begin
      cop_ans_valid <= is_arg;
      if (is_arg)
      begin
        case (out_sel)
          2'h0:    cop_ans.data <= res_a_next[15:0];
          2'h1:    cop_ans.data <= res_a_next[31:16];
          2'h2:    cop_ans.data <= res_b_next[15:0];
          default: cop_ans.data <= res_b_next[31:16];
        endcase
        cop_ans.flags <= (is_mac && ovf_now) ? mcr_pkg::MCR_FLAGS_OVF
                                             : mcr_pkg::MCR_FLAGS_NONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status, mask and interrupt
  // ----------------------------------------------------------------
  assign w1c = (wr_fire && awaddr_reg == mcr_pkg::MCR_ADDR_STATUS && wstrb0_reg)
               ? wdata_reg[1:0] : 2'b00;
  // Set beats clear so an event in the clearing cycle survives
  assign status_next = (status_reg & ~w1c) |
                       {is_arg && is_mac, is_arg && is_mac && ovf_now};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_reg <= 2'b00;
      mask_reg   <= 2'b00;
      irq        <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      if (wr_fire && awaddr_reg == mcr_pkg::MCR_ADDR_MASK && wstrb0_reg)
        mask_reg <= wdata_reg[1:0];
      irq <= |(status_next & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;

  // Address and data are taken in either order and held until the response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb0_reg    <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= mcr_pkg::MCR_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_reg    <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_reg    <= 1'b1;
        wdata_reg    <= s_axi_wdata;
        wstrb0_reg   <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_reg > mcr_pkg::MCR_ADDR_FLAG || awaddr_reg[1:0] != 2'b00)
                        ? mcr_pkg::MCR_RESP_DECERR : mcr_pkg::MCR_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        aw_got_reg    <= 1'b0;
        w_got_reg     <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read path answers one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= mcr_pkg::MCR_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= mcr_pkg::MCR_RESP_OKAY;
      case (s_axi_araddr)
        mcr_pkg::MCR_ADDR_STATUS: s_axi_rdata <= {30'h0, status_reg};
        mcr_pkg::MCR_ADDR_MASK:   s_axi_rdata <= {30'h0, mask_reg};
        mcr_pkg::MCR_ADDR_MODE:   s_axi_rdata <= {25'h0, mode_reg};
        mcr_pkg::MCR_ADDR_RES_A:  s_axi_rdata <= res_a_reg;
        mcr_pkg::MCR_ADDR_RES_B:  s_axi_rdata <= res_b_reg;
        mcr_pkg::MCR_ADDR_FLAG:   s_axi_rdata <= {31'h0, ovf_reg};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= mcr_pkg::MCR_RESP_DECERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_mac_step;
    is_arg && op == mcr_pkg::MCR_OP_MAC_S && ovf_now;
  endsequence

  sequence s_read_step;
    is_arg && op == mcr_pkg::MCR_OP_READ;
  endsequence

  a_clear_both: assert property (
    is_mode && cop_cmd.op_a[3:0] == 4'h0 |=> res_a_reg == 32'h0 && res_b_reg == 32'h0)
    else $error("mode 0 did not clear results");

  a_load_low: assert property (
    is_load && op == 4'h1 |=> res_a_reg == {16'h0000, $past(cop_cmd.op_b)})
    else $error("16-bit load wrong");

  a_load_wide: assert property (
    is_load && op == 4'h2 |=> res_a_reg == {$past(cop_cmd.op_a), $past(cop_cmd.op_b)})
    else $error("32-bit load wrong");

  a_mac_unsigned: assert property (
    is_arg && op == 4'h6 |=> res_a_reg == $past(res_a_reg)
      + {16'h0000, $past(cop_cmd.op_a)} * {16'h0000, $past(cop_cmd.op_b)})
    else $error("unsigned accumulate sum wrong");

  a_unsigned_clean: assert property (
    is_arg && op == 4'h6 |=> !ovf_reg && cop_ans.flags == 4'h0)
    else $error("unsigned accumulate reported overflow");

  a_ovf_hold: assert property (
    s_mac_step |=> ovf_reg && cop_ans.flags == 4'h4 && res_a_reg == $past(res_a_reg))
    else $error("overflow step changed result");

  a_ovf_clear: assert property (
    is_load && op != mcr_pkg::MCR_OP_READ |=> !ovf_reg)
    else $error("load did not clear overflow");

  a_read_keep: assert property (
    s_read_step |=> $stable(res_a_reg) && $stable(res_b_reg) && cop_ans.flags == 4'h0)
    else $error("read transfer disturbed state");

  a_read_high: assert property (
    s_read_step ##0 out_sel == 2'h1 |=> cop_ans.data == $past(res_a_reg[31:16]))
    else $error("read of high half wrong");

  a_answer_once: assert property (
    is_arg |=> cop_ans_valid ##1 !cop_ans_valid || $past(is_arg))
    else $error("answer strobe wrong");

endmodule : mcr_result_path

/* File: verification/mcr_cpu_model.sv */
/*
  CPU core model for the coprocessor port: mode writes, initial loads
  and argument transfers, answers collected 1 ns after the taking edge.
  Assumes every task is entered right after a rising edge of aclk.
*/
`timescale 1ns/1ps
module mcr_cpu_model (
  // Clock
  input  wire logic                 aclk,
  // Commands to the coprocessor
  output      logic                 cop_valid,
  output      mcr_pkg::mcr_cmd_type cop_cmd,
  // Answers back
  input  wire logic                 cop_ans_valid,
  input  wire mcr_pkg::mcr_rsp_type cop_ans
);
  // Idle at time zero
  initial
  begin
    cop_valid = 1'b0;
    cop_cmd   = '{mcr_pkg::MCR_CMD_NONE, 16'h0000, 16'h0000};
  end

  // One command, taken at the next edge; released operands flip
  task automatic issue(input mcr_pkg::mcr_cmd_kind_type k, input logic [15:0] a, b);
    cop_valid <= 1'b1;
    cop_cmd   <= '{k, a, b};
    @(posedge aclk);
    cop_valid <= 1'b0;
    cop_cmd   <= '{mcr_pkg::MCR_CMD_NONE, ~a, ~b};
  endtask : issue

  // Seven-bit mode rides in the low bits of the first operand
  task automatic mode_write(input logic [6:0] m);
    issue(mcr_pkg::MCR_CMD_MODE_WRITE, {9'h000, m}, 16'h0000);
    @(posedge aclk);
  endtask : mode_write

  // Initial value load
  task automatic load(input logic [15:0] a, b);
    issue(mcr_pkg::MCR_CMD_INIT_LOAD, a, b);
    @(posedge aclk);
  endtask : load

  // One operand pair per product term; answer sampled after the take
  task automatic xfer(input logic [15:0] a, b, output logic [15:0] d,
                      output logic [3:0] f, output logic v);
    issue(mcr_pkg::MCR_CMD_ARG_XFER, a, b);
    #1;
    v = cop_ans_valid;
    d = cop_ans.data;
    f = cop_ans.flags;
    @(posedge aclk);
  endtask : xfer
endmodule : mcr_cpu_model

/* File: verification/mcr_result_path_tb_top.sv */
/*
  Self-checking bench: coprocessor traffic through the CPU model,
  registers and interrupt over AXI4-Lite. Assumes package compiled first.
*/
`timescale 1ns/1ps
module mcr_result_path_tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                 aclk, aresetn, cop_valid, cop_ans_valid, irq;
  mcr_pkg::mcr_cmd_type cop_cmd;
  mcr_pkg::mcr_rsp_type cop_ans;
  logic                 awvalid, awready, wvalid, wready, bvalid, bready;
  logic                 arvalid, arready, rvalid, rready;
  logic [7:0]           awaddr, araddr;
  logic [31:0]          wdata, rdata;
  logic [3:0]           wstrb;
  logic [1:0]           bresp, rresp;
  int                   mismatches, tests_run;

  // 40 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  mcr_result_path dut_u (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .cop_valid     (cop_valid),
    .cop_cmd       (cop_cmd),
    .cop_ans_valid (cop_ans_valid),
    .cop_ans       (cop_ans),
    .s_axi_awvalid (awvalid),
    .s_axi_awready (awready),
    .s_axi_awaddr  (awaddr),
    .s_axi_wvalid  (wvalid),
    .s_axi_wready  (wready),
    .s_axi_wdata   (wdata),
    .s_axi_wstrb   (wstrb),
    .s_axi_bvalid  (bvalid),
    .s_axi_bready  (bready),
    .s_axi_bresp   (bresp),
    .s_axi_arvalid (arvalid),
    .s_axi_arready (arready),
    .s_axi_araddr  (araddr),
    .s_axi_rvalid  (rvalid),
    .s_axi_rready  (rready),
    .s_axi_rdata   (rdata),
    .s_axi_rresp   (rresp),
    .irq           (irq)
  );

  mcr_cpu_model cpu_u (
    .aclk          (aclk),
    .cop_valid     (cop_valid),
    .cop_cmd       (cop_cmd),
    .cop_ans_valid (cop_ans_valid),
    .cop_ans       (cop_ans)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Address and data offered together; extra edge keeps drives apart
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
                     input logic [3:0] s = 4'hf);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    bready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge aclk);
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    chk({30'h0, rresp}, {30'h0, er});
    if (er === mcr_pkg::MCR_RESP_OKAY) chk(rdata, e);
    @(posedge aclk);
  endtask : axr

  // Accumulate or read step without touching the mode
  task automatic ac(input logic [15:0] a, b, ed, input logic [3:0] ef);
    logic [15:0] d;
    logic [3:0]  f;
    logic        v;
    cpu_u.xfer(a, b, d, f, v);
    chk({31'h0, v}, 32'h1);
    chk({16'h0, d}, {16'h0, ed});
    chk({28'h0, f}, {28'h0, ef});
  endtask : ac

  task automatic xc(input logic [6:0] m, input logic [15:0] ed);
    cpu_u.mode_write(m);
    ac(16'h0005, 16'h0006, ed, mcr_pkg::MCR_FLAGS_NONE);
  endtask : xc

  task automatic irqchk(input logic e);
    #1;
    chk({31'h0, irq}, {31'h0, e});
  endtask : irqchk

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] regs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    foreach (regs[i]) axr(regs[i], 32'h0, mcr_pkg::MCR_RESP_OKAY);
    axr(8'h18, 32'h0, mcr_pkg::MCR_RESP_DECERR);
    irqchk(1'b0);
  endtask : t_reset

  task automatic t_init();
    cpu_u.mode_write(7'h01);
    cpu_u.load(16'hffff, 16'h1234);
    xc(7'h03, 16'h1234);
    xc(7'h13, 16'h0000);
    cpu_u.mode_write(7'h02);
    cpu_u.load(16'hdead, 16'hbeef);
    xc(7'h03, 16'hbeef);
    xc(7'h13, 16'hdead);
    cpu_u.mode_write(7'h0a);
    cpu_u.load(16'h1111, 16'h2222);
    xc(7'h23, 16'h2222);
    xc(7'h33, 16'h1111);
    axr(mcr_pkg::MCR_ADDR_RES_A, 32'hdeadbeef, mcr_pkg::MCR_RESP_OKAY);
    cpu_u.mode_write(7'h00);
    axr(mcr_pkg::MCR_ADDR_RES_A, 32'h0, mcr_pkg::MCR_RESP_OKAY);
    axr(mcr_pkg::MCR_ADDR_RES_B, 32'h0, mcr_pkg::MCR_RESP_OKAY);
  endtask : t_init

  // Signed-overflow operands in unsigned mode must still update
  task automatic t_umac();
    cpu_u.mode_write(7'h02);
    cpu_u.load(16'h7fff, 16'h0000);
    cpu_u.mode_write(7'h06);
    ac(16'h7fff, 16'h7fff, 16'h0001, mcr_pkg::MCR_FLAGS_NONE);
    cpu_u.mode_write(7'h16);
    ac(16'hffff, 16'hffff, 16'hbffc, mcr_pkg::MCR_FLAGS_NONE);
    xc(7'h03, 16'h0002);
    xc(7'h13, 16'hbffc);
    axr(mcr_pkg::MCR_ADDR_RES_A, 32'hbffc0002, mcr_pkg::MCR_RESP_OKAY);
  endtask : t_umac

  task automatic t_axi();
    axw(mcr_pkg::MCR_ADDR_MODE, 32'h00000013, mcr_pkg::MCR_RESP_OKAY);
    axr(mcr_pkg::MCR_ADDR_MODE, 32'h00000013, mcr_pkg::MCR_RESP_OKAY);
    // Byte lane 0 off: the mode write must be dropped
    axw(mcr_pkg::MCR_ADDR_MODE, 32'h0000007f, mcr_pkg::MCR_RESP_OKAY, 4'he);
    axr(mcr_pkg::MCR_ADDR_MODE, 32'h00000013, mcr_pkg::MCR_RESP_OKAY);
    ac(16'h0000, 16'h0000, 16'hbffc, mcr_pkg::MCR_FLAGS_NONE);
    axw(mcr_pkg::MCR_ADDR_RES_A, 32'hffffffff, mcr_pkg::MCR_RESP_OKAY);
    axr(mcr_pkg::MCR_ADDR_RES_A, 32'hbffc0002, mcr_pkg::MCR_RESP_OKAY);
    axw(8'h18, 32'h0, mcr_pkg::MCR_RESP_DECERR);
  endtask : t_axi

  task automatic t_smac();
    cpu_u.mode_write(7'h02);
    cpu_u.load(16'h7fff, 16'h0000);
    cpu_u.mode_write(7'h07);
    ac(16'h7fff, 16'h7fff, 16'h0000, mcr_pkg::MCR_FLAGS_OVF);
    irqchk(1'b0);
    axr(mcr_pkg::MCR_ADDR_RES_A, 32'h7fff0000, mcr_pkg::MCR_RESP_OKAY);
    xc(7'h13, 16'h7fff);
    axr(mcr_pkg::MCR_ADDR_FLAG, 32'h1, mcr_pkg::MCR_RESP_OKAY);
    cpu_u.mode_write(7'h07);
    ac(16'h0001, 16'h0001, 16'h0001, mcr_pkg::MCR_FLAGS_NONE);
    axr(mcr_pkg::MCR_ADDR_RES_A, 32'h7fff0001, mcr_pkg::MCR_RESP_OKAY);
    cpu_u.mode_write(7'h02);
    cpu_u.load(16'h8000, 16'h0000);
    cpu_u.mode_write(7'h07);
    ac(16'h7fff, 16'h8000, 16'h0000, mcr_pkg::MCR_FLAGS_OVF);
    axw(mcr_pkg::MCR_ADDR_MASK, 32'h1, mcr_pkg::MCR_RESP_OKAY);
    irqchk(1'b1);
    axr(mcr_pkg::MCR_ADDR_STATUS, 32'h3, mcr_pkg::MCR_RESP_OKAY);
    axw(mcr_pkg::MCR_ADDR_STATUS, 32'h3, mcr_pkg::MCR_RESP_OKAY);
    irqchk(1'b0);
    axr(mcr_pkg::MCR_ADDR_STATUS, 32'h0, mcr_pkg::MCR_RESP_OKAY);
    cpu_u.mode_write(7'h02);
    cpu_u.load(16'h0000, 16'h0000);
    axr(mcr_pkg::MCR_ADDR_FLAG, 32'h0, mcr_pkg::MCR_RESP_OKAY);
  endtask : t_smac

  // Reset in mid-run with live state must bring everything back to zero
  task automatic t_rerst();
    cpu_u.mode_write(7'h02);
    cpu_u.load(16'h1234, 16'h5678);
    axw(mcr_pkg::MCR_ADDR_MASK, 32'h3, mcr_pkg::MCR_RESP_OKAY);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    chk({11'h0, cop_ans_valid, cop_ans}, 32'h0);
  endtask : t_rerst

  // ----------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // Whole run needs a few hundred cycles; generous margin
  initial
  begin
    #200000;
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    mismatches = 0;
    tests_run  = 0;
    aresetn    = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_init();
    t_umac();
    t_axi();
    t_smac();
    t_rerst();
    report_and_stop();
  end
endmodule : mcr_result_path_tb_top
